/* pkg/serial_flash_map.vh */
/*
 * Constants for the serial flash command front end: opcodes, the layout of
 * the three address bytes in 528-byte page mode, dummy bit counts and the
 * power-up timing figures. Included by bare name; holds definitions only.
 */
`ifndef SERIAL_FLASH_MAP_VH
`define SERIAL_FLASH_MAP_VH

// ****************************************************************
// opcodes of the decoded group
// ****************************************************************
`define OPC_BUF1_READ_SLOW   8'hD1
`define OPC_PAGE_READ        8'hD2
`define OPC_BUF2_READ_SLOW   8'hD3
`define OPC_BUF1_READ        8'hD4
`define OPC_BUF2_READ        8'hD6
`define OPC_STATUS_READ      8'hD7

// ****************************************************************
// framing: bit counts and address field positions
// ****************************************************************
`define OPCODE_BITS          6'h08
`define ADDR_BITS            6'h18
`define PAGE_ADDR_MSB        22
`define PAGE_ADDR_LSB        10
`define BYTE_ADDR_MSB        9
`define BYTE_ADDR_LSB        0
`define DUMMY_BITS_PAGE      6'h20
`define DUMMY_BITS_BUF       6'h08
`define DUMMY_BITS_NONE      6'h00

// ****************************************************************
// power-up timing
// ****************************************************************
`define CLK_FREQ_KHZ         250000
`define FIRST_WRITE_WAIT_MS  3

`endif

/* design/serial_flash_frontend.v */
/*
 * Command front end of a serial flash: power-on/reset state, SPI mode
 * detection on each chip-select fall, opcode shift-in and address/dummy
 * framing for the decoded opcodes, and the power-up write-hold timer.
 * Assumes the pins arrive asynchronously to clk and that sck runs well
 * below half the clk rate, so every sck edge is seen after synchronising.
 */
`timescale 1ns/1ns
`include "serial_flash_map.vh"

// Behaviour
// - after power-up or reset the recorded serial mode is mode 3
// - after power-up or reset the serial output is not driven
// - no instruction accepted until chip select falls after reset
// - each chip select fall samples idle sck level: high mode 3, low mode 0
// - while power-on reset is active everything is held and commands ignored
// - when power-up completes the device stands by, ready for a command
// - address bytes: reserved bit, 13-bit page address, 10-bit byte address
// - dummy bytes per opcode are counted and their bits ignored
module serial_flash_frontend #(
  parameter WRITE_WAIT_CYCLES = `FIRST_WRITE_WAIT_MS * (`CLK_FREQ_KHZ)
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // power-on reset level from the supply monitor
  input  wire        power_on_reset_threshold,
  // serial pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output wire        so_out,
  output wire        so_oe,
  // status
  output reg         standby,
  output reg         mode3,
  output reg         armed,
  output reg         write_allowed,
  // decoded command
  output reg         cmd_valid,
  output reg         cmd_unknown,
  output reg  [7:0]  opcode,
  output reg  [12:0] page_address_bits,
  output reg  [9:0]  byte_address_bits
);

  // ****************************************************************
  // state encoding
  // ****************************************************************
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_OPC   = 5'h02;
  localparam [4:0] ST_ADDR  = 5'h04;
  localparam [4:0] ST_DUMMY = 5'h08;
  localparam [4:0] ST_SKIP  = 5'h10;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [3:0] meta_q;
  reg [3:0] sync_q;
  reg       cs_prev_q;
  reg       sck_prev_q;

  always @(posedge clk) begin
    if (rst) begin
      // idle levels; the supply bit resets high, so hold outlasts rst by two cycles
      meta_q <= 4'hF;
      sync_q <= 4'hF;
    end else begin
      meta_q <= {power_on_reset_threshold, cs_n, sck, si};
      sync_q <= meta_q;
    end
  end

  // every pin read past this point is a synchronised copy
  wire por_s  = sync_q[3];
  wire cs_s   = sync_q[2];
  wire sck_s  = sync_q[1];
  wire si_s   = sync_q[0];
  // power-on reset acts as a full reset of everything past the synchronisers
  wire hold   = rst | por_s;
  wire cs_fall = cs_prev_q & ~cs_s;
  wire sck_rise = ~sck_prev_q & sck_s;

  // the serial output stays released; this front end never returns data
  assign so_out = 1'b0;
  assign so_oe  = 1'b0;

  // ****************************************************************
  // power-up write hold timer
  // ****************************************************************
  // counts from the end of rst or supply-monitor reset, which stand in for supply good;
  // it then stops, so write_allowed stays up until the next reset
  reg [31:0] wait_q;

  always @(posedge clk) begin
    if (hold) begin
      wait_q        <= 32'h0;
      write_allowed <= 1'b0;
    end else if (wait_q >= WRITE_WAIT_CYCLES - 1) begin
      write_allowed <= 1'b1;
    end else begin
      wait_q <= wait_q + 32'h1;
    end
  end

  // ****************************************************************
  // command framing
  // ****************************************************************
  reg [4:0]  state_q;
  // six bits hold the longest run, 32 dummy bits after the page read opcode
  reg [5:0]  cnt_q;
  reg [5:0]  dummy_q;
  reg [23:0] shift_q;
  wire [23:0] shift_d = {shift_q[22:0], si_s};

  always @(posedge clk) begin
    if (hold) begin
      // cs_prev starts low so a select held low across reset never arms
      cs_prev_q         <= 1'b0;
      sck_prev_q        <= 1'b1;
      state_q           <= ST_IDLE;
      cnt_q             <= 6'h0;
      dummy_q           <= 6'h0;
      shift_q           <= 24'h0;
      standby           <= 1'b0;
      mode3             <= 1'b1;
      armed             <= 1'b0;
      cmd_valid         <= 1'b0;
      cmd_unknown       <= 1'b0;
      opcode            <= 8'h00;
      page_address_bits <= 13'h0;
      byte_address_bits <= 10'h0;
    end else begin
      cs_prev_q   <= cs_s;
      sck_prev_q  <= sck_s;
      standby     <= cs_s;
      cmd_valid   <= 1'b0;
      cmd_unknown <= 1'b0;
      if (cs_fall) begin
        // mode is only reported: both modes take si on the rising sck edge
        mode3   <= sck_s;
        armed   <= 1'b1;
        state_q <= ST_OPC;
        cnt_q   <= 6'h0;
        shift_q <= 24'h0;
      end else if (cs_s) begin
        // a select rise mid-frame drops back to idle, so a cut frame gives no pulse
        state_q <= ST_IDLE;
      end else if (sck_rise) begin
        case (state_q)
          ST_OPC: begin
            shift_q <= shift_d;
            if (cnt_q == `OPCODE_BITS - 6'h1) begin
              // opcode complete, msb arrived first
              opcode <= shift_d[7:0];
              cnt_q  <= 6'h0;
              case (shift_d[7:0])
                `OPC_STATUS_READ: begin
                  cmd_valid <= 1'b1;
                  state_q   <= ST_SKIP;
                end
                `OPC_PAGE_READ: begin
                  dummy_q <= `DUMMY_BITS_PAGE;
                  state_q <= ST_ADDR;
                end
                `OPC_BUF1_READ, `OPC_BUF2_READ: begin
                  dummy_q <= `DUMMY_BITS_BUF;
                  state_q <= ST_ADDR;
                end
                `OPC_BUF1_READ_SLOW, `OPC_BUF2_READ_SLOW: begin
                  dummy_q <= `DUMMY_BITS_NONE;
                  state_q <= ST_ADDR;
                end
                default: begin
                  cmd_unknown <= 1'b1;
                  state_q     <= ST_SKIP;
                end
              endcase
            end else begin
              cnt_q <= cnt_q + 6'h1;
            end
          end
          ST_ADDR: begin
            shift_q <= shift_d;
            if (cnt_q == `ADDR_BITS - 6'h1) begin
              // reserved top bit dropped
              page_address_bits <= shift_d[`PAGE_ADDR_MSB:`PAGE_ADDR_LSB];
              byte_address_bits <= shift_d[`BYTE_ADDR_MSB:`BYTE_ADDR_LSB];
              cnt_q <= 6'h0;
              if (dummy_q == `DUMMY_BITS_NONE) begin
                cmd_valid <= 1'b1;
                state_q   <= ST_SKIP;
              end else begin
                state_q <= ST_DUMMY;
              end
            end else begin
              cnt_q <= cnt_q + 6'h1;
            end
          end
          ST_DUMMY: begin
            // dummy bit values are never looked at
            if (cnt_q == dummy_q - 6'h1) begin
              cmd_valid <= 1'b1;
              state_q   <= ST_SKIP;
            end else begin
              cnt_q <= cnt_q + 6'h1;
            end
          end
          default: begin
            // rest of an unknown or finished frame is ignored until select rises
            state_q <= state_q;
          end
        endcase
      end
    end
  end

endmodule

/* verif/serial_flash_frontend_monitor.sv */
/* port checker for the serial flash command front end.
   bound from the bench top file; watches design ports only. */
`timescale 1ns/1ns
module serial_flash_frontend_monitor #(
  parameter WRITE_WAIT_CYCLES = 750000
) (
  // clock and resets
  input wire       clk,
  input wire       rst,
  input wire       power_on_reset_threshold,
  // serial pins
  input wire       cs_n,
  input wire       sck,
  input wire       so_oe,
  // status and command
  input wire       standby,
  input wire       mode3,
  input wire       armed,
  input wire       write_allowed,
  input wire       cmd_valid,
  input wire       cmd_unknown,
  input wire [7:0] opcode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || power_on_reset_threshold);
  reg  [31:0] up_q;
  wire        known = opcode inside {8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7};
  // the design sees the supply monitor two cycles late, hence the slack
  always @(posedge clk)
    if (rst || power_on_reset_threshold)
      up_q <= 32'h0;
    else if (~&up_q)
      up_q <= up_q + 32'h1;
  sequence sel_fall_s;
    $fell(cs_n) ##1 !cs_n;
  endsequence
  oe_idle_a: assert property (!so_oe)
    else $error("serial out driven");
  rst_state_a: assert property ($past(rst) |-> mode3 && !armed && !write_allowed)
    else $error("state after reset wrong");
  por_state_a: assert property (@(posedge clk) disable iff (rst)
    $past(power_on_reset_threshold, 3) && power_on_reset_threshold |-> !armed && mode3 && !standby)
    else $error("supply reset not holding");
  mode_pick_a: assert property (sel_fall_s |-> ##4 (armed && mode3 == sck))
    else $error("mode not taken at select");
  unarmed_quiet_a: assert property (!armed |-> !cmd_valid && !cmd_unknown)
    else $error("command before select fall");
  unknown_op_a: assert property (cmd_unknown |-> !known)
    else $error("known opcode flagged");
  valid_op_a: assert property (cmd_valid |-> known && !cs_n)
    else $error("command end without frame");
  standby_a: assert property (cs_n [*8] |-> standby)
    else $error("not standing by");
  write_hold_a: assert property (up_q < WRITE_WAIT_CYCLES |-> !write_allowed)
    else $error("write allowed early");
  write_open_a: assert property (up_q > WRITE_WAIT_CYCLES + 4 |-> write_allowed)
    else $error("write never allowed");
endmodule

/* verif/host_spi_model.sv */
/* host controller model: drives select, serial clock and data in.
   moves on the falling clk edge; half a link period is 8 clk cycles. */
`timescale 1ns/1ns
module host_spi_model (
  // clock
  input  wire clk,
  // serial pins
  output reg  cs_n,
  output reg  sck,
  output reg  si
);
  task automatic half;
    repeat (8) @(negedge clk);
  endtask
  // n bits msb first from the top of bits; fewer bits abort the frame
  task automatic send(input reg m3, input reg [63:0] bits, input integer n);
    integer i;
    begin
      sck = m3;
      half;
      cs_n = 1'b0;
      half;
      for (i = 0; i < n; i = i + 1) begin
        sck = 1'b0;
        si = bits[63 - i];
        half;
        sck = 1'b1;
        half;
      end
      sck = m3;
      half;
      cs_n = 1'b1;
      // a released line must not keep showing the last bit
      si = ~si;
      half;
    end
  endtask
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end
endmodule

/* verif/serial_flash_frontend_tb.sv */
/* self-checking bench: random frames of each decoded opcode, unknown
   opcodes, aborted frames, both modes, supply reset and write hold.
   assumes the host model and the port checker are compiled before it. */
`timescale 1ns/1ns
module serial_flash_frontend_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         por = 1'b0;
  wire        cs_n, sck, si, so_oe, stb, m3o, arm, wok, vld, unk;
  wire [7:0]  opc;
  wire [12:0] pg;
  wire [9:0]  ba;
  reg  [31:0] rnd = 32'h764644AA;
  reg  [55:0] ops = 56'hD1D2D3D4D6D700;
  reg  [7:0]  op;
  reg         m3, cut;
  integer     fail_count = 0, n_tests = 0, cyc = 0, nv = 0, nu = 0, k, bv = 0, bu = 0;
  // 85 us at the 4 ns clock
  localparam integer SELECT_WAIT_CYCLES = 21250;
  always #2 clk = ~clk;
  serial_flash_frontend #(.WRITE_WAIT_CYCLES(100)) i_dut (.clk(clk), .rst(rst),
    .power_on_reset_threshold(por), .cs_n(cs_n), .sck(sck), .si(si), .so_out(),
    .so_oe(so_oe), .standby(stb), .mode3(m3o), .armed(arm), .write_allowed(wok),
    .cmd_valid(vld), .cmd_unknown(unk), .opcode(opc), .page_address_bits(pg),
    .byte_address_bits(ba));
  host_spi_model i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
  function [31:0] lfsr(input [31:0] r);
    lfsr = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  function integer flen(input [7:0] o);
    case (o)
      8'hD2: flen = 64;
      8'hD4, 8'hD6: flen = 40;
      8'hD1, 8'hD3: flen = 32;
      default: flen = 8;
    endcase
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nv <= nv + vld;
    nu <= nu + unk;
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check(m3o, 1);
    check(so_oe, 0);
    check(arm, 0);
    repeat (20) @(negedge clk);
    check(stb, 1);
    check(wok, 0);
    // no select until 85 us after supply good
    repeat (SELECT_WAIT_CYCLES - 20) @(negedge clk);
    for (k = 0; k < 26; k = k + 1) begin
      rnd = lfsr(rnd);
      op = (k % 7 == 6) ? {1'b0, rnd[6:0]} : ops[55 - 8 * (k % 7) -: 8];
      m3 = rnd[8];
      cut = rnd[9] & op[7] & (op != 8'hD7);
      bv = nv;
      bu = nu;
      i_host.send(m3, {op, rnd[31:8], rnd}, flen(op) - cut);
      check(m3o, m3);
      check(opc, op);
      check(nu - bu, !op[7]);
      check(nv - bv, op[7] & !cut);
      if (op[7] && op != 8'hD7 && !cut) begin
        check(pg, rnd[30:18]);
        check(ba, rnd[17:8]);
      end
    end
    check(wok, 1);
    // select already low when a mid-run reset ends: the whole frame is ignored
    bv = nv;
    bu = nu;
    fork
      i_host.send(1'b0, {8'hD7, rnd, 24'h0}, 64);
      begin
        rst = 1'b1;
        repeat (40) @(negedge clk);
        rst = 1'b0;
      end
    join
    check(m3o, 1);
    check(arm, 0);
    check(nv - bv + nu - bu, 0);
    i_host.send(1'b0, {8'hD7, 56'h0}, 8);
    check(arm, 1);
    check(m3o, 0);
    check(nv - bv, 1);
    por = 1'b1;
    repeat (5) @(negedge clk);
    check({m3o, arm, wok, stb}, 4'h8);
    por = 1'b0;
    repeat (20) @(negedge clk);
    check(stb, 1);
    report_and_stop;
  end
endmodule
bind serial_flash_frontend serial_flash_frontend_monitor #(
  .WRITE_WAIT_CYCLES(WRITE_WAIT_CYCLES)
) i_mon (.clk(clk), .rst(rst), .power_on_reset_threshold(power_on_reset_threshold),
  .cs_n(cs_n), .sck(sck), .so_oe(so_oe), .standby(standby), .mode3(mode3),
  .armed(armed), .write_allowed(write_allowed), .cmd_valid(cmd_valid),
  .cmd_unknown(cmd_unknown), .opcode(opcode));
